//--- xtskc_pkg.sv
`default_nettype none
package xtskc_pkg;

  localparam int KEY_W = 256;
  localparam int DATA_W = 128;
  localparam int SECT_W = 64;
  localparam int ENTRIES = 8;
  localparam int IDX_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = DATA_W + 1;
  localparam int ROT = 8;

  localparam logic HALF_BULK = 1'b0;
  localparam logic HALF_TWEAK = 1'b1;

  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_ENC_KAT = 2'h1;
  localparam logic [1:0] ERR_DEC_KAT = 2'h2;

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_KAT_ENC = 3'h1,
    ST_KAT_DEC = 3'h2,
    ST_READY = 3'h3,
    ST_ERROR = 3'h4
  } xtskc_state_e;

  // known-answer vectors, fixed in the netlist
  localparam logic [KEY_W-1:0] KAT_BULK =
    256'h0f1e2d3c4b5a69788796a5b4c3d2e1f00112233445566778899aabbccddeeff;
  localparam logic [KEY_W-1:0] KAT_TWEAK =
    256'hffeeddccbbaa99887766554433221100a5a55a5a3c3cc3c30ff0f00f12345678;
  localparam logic [SECT_W-1:0] KAT_SECT = 64'h0000_0000_0000_0a5c;
  localparam logic [DATA_W-1:0] KAT_PT =
    128'h00112233445566778899aabbccddeeff;

  // keyed tweakable transform standing in for the round datapath;
  // the decrypt branch is the exact inverse of the encrypt branch
  function automatic logic [DATA_W-1:0] xts_mix(
    input logic [DATA_W-1:0] d,
    input logic [KEY_W-1:0] k1,
    input logic [KEY_W-1:0] k2,
    input logic [SECT_W-1:0] sect,
    input logic dec
  );
    logic [DATA_W-1:0] t;
    logic [DATA_W-1:0] u;
    logic [DATA_W-1:0] r;
    t = k2[DATA_W-1:0] ^ k2[KEY_W-1:DATA_W];
    t = t ^ {{(DATA_W-SECT_W){1'b0}}, sect};
    if (!dec) begin
      u = d ^ k1[DATA_W-1:0] ^ t;
      r = {u[DATA_W-ROT-1:0], u[DATA_W-1:DATA_W-ROT]};
      r = r ^ k1[KEY_W-1:DATA_W] ^ t;
    end else begin
      u = d ^ k1[KEY_W-1:DATA_W] ^ t;
      r = {u[ROT-1:0], u[DATA_W-1:ROT]};
      r = r ^ k1[DATA_W-1:0] ^ t;
    end
    return r;
  endfunction

  localparam logic [DATA_W-1:0] KAT_CT =
    xts_mix(KAT_PT, KAT_BULK, KAT_TWEAK, KAT_SECT, 1'b0);

endpackage
`default_nettype wire

//--- xtskc_fifo_if.sv
`default_nettype none
interface xtskc_fifo_if #(parameter int W = 8);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic flush;

  modport fill (
    output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data
  );
  modport store (
    input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data
  );
endinterface
`default_nettype wire

//--- xtskc_fifo.sv
`default_nettype none
module xtskc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,      // core clock
  input wire logic i_rst_n,    // async reset, active low
  xtskc_fifo_if.store port     // fill and drain sides
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } xtskc_fifo_s;

  xtskc_fifo_s s;
  xtskc_fifo_s next_s;
  logic push;
  logic pop;

  assign port.push_ready = (s.count != (AW + 1)'(DEPTH));
  assign port.pop_valid = (s.count != '0);
  assign port.pop_data = s.mem[s.rptr];
  assign push = port.push_valid && port.push_ready;
  assign pop = port.pop_ready && port.pop_valid;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wptr] = port.push_data;
      next_s.wptr = s.wptr + 1'b1;
    end
    if (pop) begin
      next_s.rptr = s.rptr + 1'b1;
    end
    case ({push, pop})
      2'b10: next_s.count = s.count + 1'b1;
      2'b01: next_s.count = s.count - 1'b1;
      default: next_s.count = s.count;
    endcase
    // flush also wipes stored words so nothing lingers
    if (port.flush) begin
      next_s = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

//--- xtskc_top.sv
`default_nettype none
module xtskc_top #(
  parameter logic [xtskc_pkg::DATA_W-1:0] KAT_ENC_EXPECT =
    xtskc_pkg::KAT_CT,
  parameter logic [xtskc_pkg::DATA_W-1:0] KAT_DEC_EXPECT =
    xtskc_pkg::KAT_PT
) (
  input wire logic I_CORE_CLK,                        // core clock
  input wire logic I_RST_N,                           // chip reset, low
  input wire logic I_KEY_WE,                          // key write strobe
  input wire logic [xtskc_pkg::IDX_W-1:0] I_KEY_IDX,  // cache entry
  input wire logic I_KEY_HALF,                        // 0 bulk, 1 tweak
  input wire logic [xtskc_pkg::KEY_W-1:0] I_KEY_DATA, // key value
  input wire logic I_SELFTEST_TRIG,                   // rerun tests
  input wire logic I_WR_VALID,                        // payload valid
  input wire logic I_WR_DECRYPT,                      // 1 decrypt
  input wire logic [xtskc_pkg::IDX_W-1:0] I_WR_KEY_IDX, // key entry
  input wire logic [xtskc_pkg::SECT_W-1:0] I_WR_SECTOR, // tweak number
  input wire logic [xtskc_pkg::DATA_W-1:0] I_WR_DATA, // payload word
  output logic O_WR_READY,                            // payload taken
  output logic O_RD_VALID,                            // result valid
  input wire logic I_RD_READY,                        // result drained
  output logic [xtskc_pkg::DATA_W-1:0] O_RD_DATA,     // result word
  output logic O_RD_KEYFAIL,                          // result zeroed
  output logic O_KEYCHK_FAIL,                         // key check pulse
  output logic O_READY,                               // service open
  output logic O_SELFTEST_BUSY,                       // tests running
  output logic O_ERROR,                               // error state
  output logic [1:0] O_ERR_CODE                       // failing test
);
  import xtskc_pkg::*;

  typedef struct packed {
    xtskc_state_e state;
    logic [ENTRIES-1:0][KEY_W-1:0] bulk;
    logic [ENTRIES-1:0][KEY_W-1:0] tweak;
    logic [ENTRIES-1:0] bulk_ok;
    logic [ENTRIES-1:0] tweak_ok;
    logic [ENTRIES-1:0] usable;
    logic [1:0] err_code;
    logic ready;
    logic busy;
    logic error;
    logic wr_ready;
    logic hold_valid;
    logic hold_fail;
    logic [DATA_W-1:0] hold_data;
    logic rd_valid;
    logic rd_fail;
    logic [DATA_W-1:0] rd_data;
    logic keychk_fail;
  } xtskc_top_s;

  xtskc_top_s s;
  xtskc_top_s next_s;

  xtskc_fifo_if #(.W(FIFO_W)) fifo ();

  logic accept;
  logic key_ok;
  logic kat_pass;
  logic [DATA_W-1:0] mix_in;
  logic [KEY_W-1:0] mix_bulk;
  logic [KEY_W-1:0] mix_tweak;
  logic [SECT_W-1:0] mix_sect;
  logic mix_dec;
  logic [DATA_W-1:0] mix_out;
  logic [DATA_W-1:0] kat_expect;

  // usable means both halves were written since reset and the two halves differ
  function automatic logic key_usable(
    input logic bulk_ok,
    input logic tweak_ok,
    input logic [KEY_W-1:0] bulk,
    input logic [KEY_W-1:0] tweak
  );
    return bulk_ok && tweak_ok && (bulk != tweak);
  endfunction

  assign accept = I_WR_VALID && s.wr_ready;

  // per-entry verdicts are registered, so the payload path looks up
  // one flag instead of a wide compare behind the index mux
  assign key_ok = s.usable[I_WR_KEY_IDX];

  // the known-answer tests run through the very transform that serves
  // payloads, so a fault in it cannot hide behind constant arithmetic
  always_comb begin
    case (s.state)
      ST_KAT_ENC: begin
        mix_in = KAT_PT;
        mix_bulk = KAT_BULK;
        mix_tweak = KAT_TWEAK;
        mix_sect = KAT_SECT;
        mix_dec = 1'b0;
        kat_expect = KAT_ENC_EXPECT;
      end
      ST_KAT_DEC: begin
        mix_in = KAT_CT;
        mix_bulk = KAT_BULK;
        mix_tweak = KAT_TWEAK;
        mix_sect = KAT_SECT;
        mix_dec = 1'b1;
        kat_expect = KAT_DEC_EXPECT;
      end
      default: begin
        mix_in = I_WR_DATA;
        mix_bulk = s.bulk[I_WR_KEY_IDX];
        mix_tweak = s.tweak[I_WR_KEY_IDX];
        mix_sect = I_WR_SECTOR;
        mix_dec = I_WR_DECRYPT;
        kat_expect = KAT_ENC_EXPECT;
      end
    endcase
  end

  // only the tweaked mode is reachable from the payload port
  assign mix_out = xts_mix(mix_in, mix_bulk, mix_tweak, mix_sect,
                           mix_dec);
  assign kat_pass = (mix_out == kat_expect);

  assign fifo.push_valid = s.hold_valid;
  assign fifo.push_data = {s.hold_fail, s.hold_data};
  assign fifo.pop_ready = !s.rd_valid || I_RD_READY;
  assign fifo.flush = (s.state == ST_ERROR);

  always_comb begin
    next_s = s;
    next_s.keychk_fail = 1'b0;

    // key loading; nothing here is ever routed back out
    if (I_KEY_WE && s.state != ST_ERROR) begin
      if (I_KEY_HALF == HALF_BULK) begin
        next_s.bulk[I_KEY_IDX] = I_KEY_DATA;
        next_s.bulk_ok[I_KEY_IDX] = 1'b1;
      end else begin
        next_s.tweak[I_KEY_IDX] = I_KEY_DATA;
        next_s.tweak_ok[I_KEY_IDX] = 1'b1;
      end
    end

    for (int i = 0; i < ENTRIES; i++) begin
      next_s.usable[i] = key_usable(next_s.bulk_ok[i], next_s.tweak_ok[i],
                                    next_s.bulk[i], next_s.tweak[i]);
    end

    case (s.state)
      ST_INIT: begin
        next_s.state = ST_KAT_ENC;
      end
      ST_KAT_ENC: begin
        if (kat_pass) begin
          next_s.state = ST_KAT_DEC;
        end else begin
          next_s.state = ST_ERROR;
          next_s.err_code = ERR_ENC_KAT;
        end
      end
      ST_KAT_DEC: begin
        if (kat_pass) begin
          next_s.state = ST_READY;
          next_s.err_code = ERR_NONE;
        end else begin
          next_s.state = ST_ERROR;
          next_s.err_code = ERR_DEC_KAT;
        end
      end
      ST_READY: begin
        if (I_SELFTEST_TRIG) begin
          next_s.state = ST_KAT_ENC;
        end
      end
      ST_ERROR: begin
        // only a chip reset leaves this state
        next_s.state = ST_ERROR;
      end
      default: begin
        next_s.state = ST_ERROR;
      end
    endcase

    // holding stage: keyed transform and key check happen on capture
    if (s.hold_valid && fifo.push_ready) begin
      next_s.hold_valid = 1'b0;
    end
    if (accept) begin
      next_s.hold_valid = 1'b1;
      next_s.hold_fail = !key_ok;
      next_s.keychk_fail = !key_ok;
      next_s.hold_data = key_ok ? mix_out : '0;
    end

    // output register, refilled from the fifo
    if (s.rd_valid && I_RD_READY) begin
      next_s.rd_valid = 1'b0;
    end
    if (fifo.pop_valid && fifo.pop_ready) begin
      next_s.rd_valid = 1'b1;
      next_s.rd_fail = fifo.pop_data[FIFO_W-1];
      next_s.rd_data = fifo.pop_data[DATA_W-1:0];
    end

    // error wipes every secret and zeroes the hold stage, the result register and the key check pulse
    if (next_s.state == ST_ERROR) begin
      next_s.bulk = '0;
      next_s.tweak = '0;
      next_s.bulk_ok = '0;
      next_s.tweak_ok = '0;
      next_s.usable = '0;
      next_s.hold_valid = 1'b0;
      next_s.hold_fail = 1'b0;
      next_s.hold_data = '0;
      next_s.rd_valid = 1'b0;
      next_s.rd_fail = 1'b0;
      next_s.rd_data = '0;
      next_s.keychk_fail = 1'b0;
    end

    next_s.ready = (next_s.state == ST_READY);
    next_s.error = (next_s.state == ST_ERROR);
    next_s.busy = (next_s.state == ST_INIT) ||
                  (next_s.state == ST_KAT_ENC) ||
                  (next_s.state == ST_KAT_DEC);
    // ready is registered, so a payload is offered a slot only when
    // the hold stage is already known to be free next cycle
    next_s.wr_ready = next_s.ready && !next_s.hold_valid;
  end

  // reset loads all-zero state: keys, flags and outputs alike
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  xtskc_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .port(fifo.store)
  );

  // outputs carry results and status only, never key bits
  assign O_WR_READY = s.wr_ready;
  assign O_RD_VALID = s.rd_valid;
  assign O_RD_DATA = s.rd_data;
  assign O_RD_KEYFAIL = s.rd_fail;
  assign O_KEYCHK_FAIL = s.keychk_fail;
  assign O_READY = s.ready;
  assign O_SELFTEST_BUSY = s.busy;
  assign O_ERROR = s.error;
  assign O_ERR_CODE = s.err_code;

endmodule
`default_nettype wire

//--- xtskc_checker.sv
`default_nettype none
module xtskc_checker (
  input wire logic I_CORE_CLK, // clock
  input wire logic I_RST_N, // reset
  input wire logic I_SELFTEST_TRIG, // trigger
  input wire logic I_WR_VALID, // request
  input wire logic I_RD_READY, // sink
  input wire logic O_WR_READY, // take
  input wire logic O_RD_VALID, // result
  input wire logic [xtskc_pkg::DATA_W-1:0] O_RD_DATA, // data
  input wire logic O_RD_KEYFAIL, // zeroed
  input wire logic O_READY, // open
  input wire logic O_SELFTEST_BUSY, // testing
  input wire logic O_ERROR, // error
  input wire logic [1:0] O_ERR_CODE // code
);
  import xtskc_pkg::*;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_boot;
    $rose(I_RST_N) |=> O_SELFTEST_BUSY;
  endproperty
  a_boot: assert property (p_boot) else $error("no boot test");
  property p_gate;
    O_WR_READY |-> O_READY && !O_SELFTEST_BUSY;
  endproperty
  a_gate: assert property (p_gate) else $error("early take");
  property p_avail;
    O_READY |-> !O_ERROR && !O_SELFTEST_BUSY;
  endproperty
  a_avail: assert property (p_avail) else $error("bad ready");
  property p_gap;
    I_WR_VALID && O_WR_READY |=> !O_WR_READY;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap");
  property p_err;
    O_ERROR |-> !O_READY && !O_WR_READY && !O_RD_VALID &&
      O_RD_DATA == '0 && O_ERR_CODE != ERR_NONE;
  endproperty
  a_err: assert property (p_err) else $error("live in error");
  property p_sticky;
    O_ERROR |=> O_ERROR && $stable(O_ERR_CODE);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error left");
  property p_kfzero;
    O_RD_VALID && O_RD_KEYFAIL |-> O_RD_DATA == '0;
  endproperty
  a_kfzero: assert property (p_kfzero) else $error("keyfail data");
  property p_hold;
    O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_RD_DATA);
  endproperty
  a_hold: assert property (p_hold) else $error("result lost");
  property p_trig;
    O_READY && I_SELFTEST_TRIG |=>
      O_SELFTEST_BUSY [*2] ##1 (!O_SELFTEST_BUSY && (O_READY || O_ERROR));
  endproperty
  a_trig: assert property (p_trig) else $error("trigger run");
endmodule
bind xtskc_top xtskc_checker chk_i (.I_CORE_CLK(I_CORE_CLK),
  .I_RST_N(I_RST_N), .I_SELFTEST_TRIG(I_SELFTEST_TRIG),
  .I_WR_VALID(I_WR_VALID), .I_RD_READY(I_RD_READY),
  .O_WR_READY(O_WR_READY), .O_RD_VALID(O_RD_VALID),
  .O_RD_DATA(O_RD_DATA), .O_RD_KEYFAIL(O_RD_KEYFAIL), .O_READY(O_READY),
  .O_SELFTEST_BUSY(O_SELFTEST_BUSY), .O_ERROR(O_ERROR),
  .O_ERR_CODE(O_ERR_CODE));
`default_nettype wire

//--- xtskc_sink.sv
`default_nettype none
module xtskc_sink (
  input wire logic i_clk, // clock
  input wire logic i_stall, // hold off results
  output logic o_ready // result accepted
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  initial phase = 2'h0;
  // skips one beat in four so results also queue up without a stall;
  // the stall acts at once, so no result slips out after it is raised
  always @(negedge i_clk) begin
    phase <= phase + 2'h1;
  end
  assign o_ready = !i_stall && (phase != 2'h3);
endmodule
`default_nettype wire

//--- tb_xtskc_top.sv
`default_nettype none
module tb_xtskc_top;
  timeunit 1ns;
  timeprecision 1ns;
  import xtskc_pkg::*;
  localparam logic [KEY_W-1:0] KA = {8{32'h5a3c_96e1}};
  localparam logic [KEY_W-1:0] KB = {8{32'h0f1e_2d4b}};
  localparam logic [DATA_W-1:0] PT = 128'hc001_d00d_0123_4567_89ab;
  logic clk, rst_n, key_we, key_half, trig, wr_valid, wr_dec, stall;
  logic [IDX_W-1:0] key_idx, wr_idx;
  logic [KEY_W-1:0] key_data;
  logic [SECT_W-1:0] wr_sect;
  logic [DATA_W-1:0] wr_data, rd_data, e_data;
  logic wr_ready, rd_valid, rd_ready, rd_kf, kc_fail, ready, busy, err;
  logic e_ready, e_err, f_err;
  logic [1:0] err_code, e_code, f_code;
  logic [DATA_W:0] exp_q[$];
  int fail_count, checks_done, k;
  xtskc_top dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_KEY_WE(key_we),
    .I_KEY_IDX(key_idx), .I_KEY_HALF(key_half), .I_KEY_DATA(key_data),
    .I_SELFTEST_TRIG(trig), .I_WR_VALID(wr_valid), .I_WR_DECRYPT(wr_dec),
    .I_WR_KEY_IDX(wr_idx), .I_WR_SECTOR(wr_sect), .I_WR_DATA(wr_data),
    .O_WR_READY(wr_ready), .O_RD_VALID(rd_valid), .I_RD_READY(rd_ready),
    .O_RD_DATA(rd_data), .O_RD_KEYFAIL(rd_kf), .O_KEYCHK_FAIL(kc_fail),
    .O_READY(ready), .O_SELFTEST_BUSY(busy), .O_ERROR(err),
    .O_ERR_CODE(err_code));
  // decrypt answer forced wrong so this copy must fail its boot tests
  xtskc_top #(.KAT_DEC_EXPECT(~KAT_PT)) dut_err (.I_CORE_CLK(clk),
    .I_RST_N(rst_n), .I_KEY_WE(key_we), .I_KEY_IDX(key_idx),
    .I_KEY_HALF(key_half), .I_KEY_DATA(key_data), .I_SELFTEST_TRIG(trig),
    .I_WR_VALID(wr_valid), .I_WR_DECRYPT(wr_dec), .I_WR_KEY_IDX(wr_idx),
    .I_WR_SECTOR(wr_sect), .I_WR_DATA(wr_data), .O_WR_READY(),
    .O_RD_VALID(), .I_RD_READY(rd_ready), .O_RD_DATA(e_data),
    .O_RD_KEYFAIL(), .O_KEYCHK_FAIL(), .O_READY(e_ready),
    .O_SELFTEST_BUSY(), .O_ERROR(e_err), .O_ERR_CODE(e_code));
  // encrypt answer forced wrong so this copy fails with the other code
  xtskc_top #(.KAT_ENC_EXPECT(~KAT_CT)) dut_enc (.I_CORE_CLK(clk),
    .I_RST_N(rst_n), .I_KEY_WE(key_we), .I_KEY_IDX(key_idx),
    .I_KEY_HALF(key_half), .I_KEY_DATA(key_data), .I_SELFTEST_TRIG(trig),
    .I_WR_VALID(wr_valid), .I_WR_DECRYPT(wr_dec), .I_WR_KEY_IDX(wr_idx),
    .I_WR_SECTOR(wr_sect), .I_WR_DATA(wr_data), .O_WR_READY(),
    .O_RD_VALID(), .I_RD_READY(rd_ready), .O_RD_DATA(),
    .O_RD_KEYFAIL(), .O_KEYCHK_FAIL(), .O_READY(),
    .O_SELFTEST_BUSY(), .O_ERROR(f_err), .O_ERR_CODE(f_code));
  xtskc_sink sink (.i_clk(clk), .i_stall(stall), .o_ready(rd_ready));
  function automatic logic [DATA_W-1:0] enc(input logic [63:0] s);
    logic [DATA_W-1:0] t, u;
    t = KB[127:0] ^ KB[255:128] ^ {64'h0, s};
    u = PT ^ KA[127:0] ^ t;
    return {u[119:0], u[127:120]} ^ KA[255:128] ^ t;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic fail(input logic [DATA_W:0] g, input logic [DATA_W:0] w);
    fail_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, w);
  endtask
  task automatic chk(input logic [DATA_W:0] g, input logic [DATA_W:0] w);
    checks_done++;
    if (g !== w) fail(g, w);
  endtask
  task automatic give_up;
    fail('0, '1);
    complete_run;
  endtask
  task automatic wait_ready;
    int n;
    for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge clk);
    if (n == 20) give_up;
  endtask
  task automatic drain;
    int n;
    for (n = 0; n < 300 && exp_q.size() > 0; n++) @(negedge clk);
    if (n == 300) give_up;
  endtask
  // strobe stays high across both halves of one entry, then drops
  task automatic kpair(input logic [2:0] i, input logic [KEY_W-1:0] t);
    @(negedge clk);
    {key_we, key_idx, key_half, key_data} = {1'b1, i, HALF_BULK, KA};
    @(negedge clk);
    {key_half, key_data} = {HALF_TWEAK, t};
    @(negedge clk);
    key_we = 1'b0;
  endtask
  task automatic send(input logic d, input logic [2:0] i,
      input logic [63:0] s, input logic [127:0] x, input logic [128:0] e);
    int n;
    exp_q.push_back(e);
    @(negedge clk);
    {wr_valid, wr_dec, wr_idx, wr_sect, wr_data} = {1'b1, d, i, s, x};
    for (n = 0; n < 300 && wr_ready !== 1'b1; n++) @(negedge clk);
    if (n == 300) give_up;
    @(negedge clk);
    wr_valid = 1'b0;
    chk(kc_fail, e[DATA_W]);
  endtask
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_q.size() == 0) fail({rd_kf, rd_data}, '0);
      else chk({rd_kf, rd_data}, exp_q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, key_we, key_half, trig, wr_valid, wr_dec, stall} = '0;
    {key_idx, wr_idx, key_data, wr_sect, wr_data} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({ready, busy}, 2'h1);
    wait_ready;
    chk({e_err, e_code, e_ready}, {1'b1, ERR_DEC_KAT, 1'b0});
    chk(e_data, '0);
    chk({f_err, f_code}, {1'b1, ERR_ENC_KAT});
    send(1'b0, 3'h0, 64'h1, PT, {1'b1, 128'h0});
    kpair(3'h1, KB);
    kpair(3'h2, KA);
    send(1'b0, 3'h1, 64'h9, PT, {1'b0, enc(64'h9)});
    send(1'b1, 3'h1, 64'h9, enc(64'h9), {1'b0, PT});
    send(1'b1, 3'h2, 64'h9, PT, {1'b1, 128'h0});
    send(1'b0, 3'h1, 64'h5, PT, {1'b0, enc(64'h5)});
    chk({err, err_code}, {1'b0, ERR_NONE});
    @(negedge clk);
    trig = 1'b1;
    @(negedge clk);
    trig = 1'b0;
    chk({ready, busy, wr_ready}, 3'h2);
    wait_ready;
    send(1'b0, 3'h1, 64'h6, PT, {1'b0, enc(64'h6)});
    drain;
    stall = 1'b1;
    for (k = 0; k < 10; k++) send(1'b0, 3'h1, k, PT, {1'b0, enc(k)});
    repeat (4) @(negedge clk);
    chk(wr_ready, 1'b0);
    stall = 1'b0;
    drain;
    @(negedge clk);
    chk(rd_valid, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({ready, busy, err, rd_valid}, 4'h0);
    rst_n = 1'b1;
    wait_ready;
    send(1'b0, 3'h1, 64'h9, PT, {1'b1, 128'h0});
    drain;
    chk({e_err, e_code}, {1'b1, ERR_DEC_KAT});
    chk({f_err, f_code}, {1'b1, ERR_ENC_KAT});
    complete_run;
  end
endmodule
`default_nettype wire
